// ==== design/mac_regs_pkg.sv ====
// Register map, field positions, reset values and timing counts for the
// MAC command, early-receive and transmit polling register block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package mac_regs_pkg;

    localparam int ADDR_W = 12;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] EARLY_RX_STATUS_IDX = 8'h36;
    localparam logic [7:0] CHIP_COMMAND_IDX = 8'h37;
    localparam logic [7:0] TX_POLL_TRIGGER_IDX = 8'h38;
    localparam logic [7:0] RX_THRESH_IDX = 8'h3A;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h3C;
    localparam logic [7:0] IRQ_FLAGS_IDX = 8'h3E;

    localparam logic [ADDR_W-1:0] EARLY_RX_STATUS_ADDR = {2'h0, EARLY_RX_STATUS_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] CHIP_COMMAND_ADDR = {2'h0, CHIP_COMMAND_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] TX_POLL_TRIGGER_ADDR = {2'h0, TX_POLL_TRIGGER_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] RX_THRESH_ADDR = {2'h0, RX_THRESH_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] IRQ_FLAGS_ADDR = {2'h0, IRQ_FLAGS_IDX, 2'h0};

    // Early receive status fields
    localparam int ERX_GOOD_BIT = 3;
    localparam int ERX_BAD_BIT = 2;
    localparam int ERX_OVW_BIT = 1;
    localparam int ERX_THRESH_BIT = 0;

    // Command fields
    localparam int CMD_SRST_BIT = 4;
    localparam int CMD_RCV_ON_BIT = 3;
    localparam int CMD_TX_ON_BIT = 2;

    // Transmit polling fields
    localparam int POLL_URGENT_BIT = 7;
    localparam int POLL_NORMAL_BIT = 6;
    localparam int POLL_FORCE_BIT = 0;

    // Interrupt flag and mask fields
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_SOFT_BIT = 8;

    // Reset values
    localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
    localparam logic [15:0] RX_THRESH_RESET = 16'h0000;

    // Software reset duration in core clock cycles
    localparam int SRST_CYCLES_DEF = 16;

endpackage : mac_regs_pkg

// ==== design/sticky_flag.sv ====
// One sticky flag: a set event wins over a clear in the same cycle.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module sticky_flag
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag_o <= 1'b0;
        else if (set_i)
            flag_o <= 1'b1;
        else if (clr_i)
            flag_o <= 1'b0;
    end

endmodule // sticky_flag

`default_nettype wire

// ==== design/mac_cmd_early_rx_regs.sv ====
// Host-visible command, early-receive status and transmit polling logic.
// Assumes APB with zero wait states and datapath events synchronous to sys_clk_i.
`timescale 1ns/10ps
`default_nettype none

module mac_cmd_early_rx_regs
    import mac_regs_pkg::*;
#(
    parameter int PTR_W = 16,
    parameter int CNT_W = 16,
    parameter int SRST_CYCLES = SRST_CYCLES_DEF
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic rx_pkt_done_i,
    input wire logic rx_pkt_err_i,
    input wire logic rx_active_i,
    input wire logic [CNT_W-1:0] rx_byte_cnt_i,
    input wire logic [PTR_W-1:0] rx_wr_ptr_i,
    input wire logic [PTR_W-1:0] host_read_ptr_i,
    input wire logic rx_rewind_i,
    input wire logic urgent_q_drained_i,
    input wire logic normal_q_drained_i,
    output logic rcv_on_o,
    output logic tx_on_o,
    output logic soft_rst_o,
    output logic urgent_queue_poll_o,
    output logic normal_queue_poll_o,
    output logic irq_o
);

    localparam int SRST_WAIT = SRST_CYCLES + 1;
    localparam int SRST_CNT_W = $clog2(SRST_CYCLES + 1);
    localparam logic [SRST_CNT_W-1:0] SRST_LAST = SRST_CNT_W'(SRST_CYCLES - 1);

    logic wr_acc, rd_acc, rd_setup, addr_hit;
    logic wr_erx, wr_cmd, wr_poll, wr_thr, wr_mask, wr_flags;
    logic [7:0] wbyte0, wbyte1, erx_status, cmd_value, poll_value;
    logic [15:0] irq_flags;
    logic [31:0] rd_mux;

    logic rcv_on_reg, tx_on_reg, srst_busy_reg, srst_start;
    logic [SRST_CNT_W-1:0] srst_cnt_reg;
    logic [15:0] rx_thresh_reg, irq_mask_reg, flags_snap_reg;
    logic [31:0] prdata_reg;

    logic early_good_pkt, early_bad_pkt, early_overwrite, early_thresh_hit;
    logic ptr_eq, ptr_eq_reg, ovw_set, thresh_cond, thresh_set;
    logic frame_done_irq, frame_err_irq, soft_irq_flag;
    logic urgent_queue_poll, normal_queue_poll, force_soft_irq;
    logic good_end, bad_end, clr_flags_rd;

    // APB decode; zero wait states
    assign pready_o = 1'b1;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign rd_acc = psel_i && penable_i && !pwrite_i;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign wbyte0 = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;
    assign wbyte1 = pstrb_i[1] ? pwdata_i[15:8] : 8'h00;

    always_comb
    begin
        addr_hit = 1'b1;
        case (paddr_i)
            EARLY_RX_STATUS_ADDR, CHIP_COMMAND_ADDR, TX_POLL_TRIGGER_ADDR,
            RX_THRESH_ADDR, IRQ_MASK_ADDR, IRQ_FLAGS_ADDR: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign pslverr_o = psel_i && penable_i && !addr_hit;
    assign wr_erx = wr_acc && (paddr_i == EARLY_RX_STATUS_ADDR);
    assign wr_cmd = wr_acc && (paddr_i == CHIP_COMMAND_ADDR);
    assign wr_poll = wr_acc && (paddr_i == TX_POLL_TRIGGER_ADDR);
    assign wr_thr = wr_acc && (paddr_i == RX_THRESH_ADDR);
    assign wr_mask = wr_acc && (paddr_i == IRQ_MASK_ADDR);
    assign wr_flags = wr_acc && (paddr_i == IRQ_FLAGS_ADDR);
    assign clr_flags_rd = rd_acc && (paddr_i == IRQ_FLAGS_ADDR);

    // Packet end events
    assign good_end = rx_pkt_done_i && !rx_pkt_err_i;
    assign bad_end = rx_pkt_done_i && rx_pkt_err_i;

    sticky_flag u_good
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flag_o(early_good_pkt),
        .set_i(good_end),
        .clr_i(wr_erx && wbyte0[ERX_GOOD_BIT])
    );

    sticky_flag u_bad
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flag_o(early_bad_pkt),
        .set_i(bad_end),
        .clr_i(wr_erx && wbyte0[ERX_BAD_BIT])
    );

    // Overwrite on the cycle pointers meet, or re-meet after an error rewind
    assign ptr_eq = (rx_wr_ptr_i == host_read_ptr_i);
    assign ovw_set = ptr_eq && (!ptr_eq_reg || rx_rewind_i);

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ptr_eq_reg <= 1'b0;
        else
            ptr_eq_reg <= ptr_eq;
    end

    sticky_flag u_ovw
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flag_o(early_overwrite),
        .set_i(ovw_set),
        .clr_i(wr_erx && wbyte0[ERX_OVW_BIT])
    );

    // Threshold flag: packet end clears it and takes priority
    assign thresh_cond = rx_active_i && rcv_on_reg
                         && (32'(rx_byte_cnt_i) > 32'(rx_thresh_reg));
    assign thresh_set = thresh_cond && !early_thresh_hit && !rx_pkt_done_i;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            early_thresh_hit <= 1'b0;
        else if (rx_pkt_done_i || srst_start)
            early_thresh_hit <= 1'b0;
        else if (thresh_set)
            early_thresh_hit <= 1'b1;
    end

    // Interrupt flags, cleared by write-one or by a read that returned them
    sticky_flag u_done
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flag_o(frame_done_irq),
        .set_i(good_end || thresh_set),
        .clr_i((wr_flags && wbyte0[IRQ_DONE_BIT])
               || (clr_flags_rd && flags_snap_reg[IRQ_DONE_BIT]))
    );

    sticky_flag u_err
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flag_o(frame_err_irq),
        .set_i(bad_end),
        .clr_i((wr_flags && wbyte0[IRQ_ERR_BIT])
               || (clr_flags_rd && flags_snap_reg[IRQ_ERR_BIT]))
    );

    sticky_flag u_soft
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flag_o(soft_irq_flag),
        .set_i(wr_poll && wbyte0[POLL_FORCE_BIT]),
        .clr_i((wr_flags && wbyte1[IRQ_SOFT_BIT-8])
               || (clr_flags_rd && flags_snap_reg[IRQ_SOFT_BIT]))
    );

    // Doorbells: writing zero never clears
    sticky_flag u_urgent
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flag_o(urgent_queue_poll),
        .set_i(wr_poll && wbyte0[POLL_URGENT_BIT]),
        .clr_i(urgent_q_drained_i)
    );

    sticky_flag u_normal
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flag_o(normal_queue_poll),
        .set_i(wr_poll && wbyte0[POLL_NORMAL_BIT]),
        .clr_i(normal_q_drained_i)
    );

    sticky_flag u_force
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .flag_o(force_soft_irq),
        .set_i(wr_poll && wbyte0[POLL_FORCE_BIT]),
        .clr_i(!soft_irq_flag)
    );

    // Software reset sequencer; touches the command enables and the early threshold flag, and drives soft_rst_o
    assign srst_start = wr_cmd && wbyte0[CMD_SRST_BIT] && !srst_busy_reg;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            srst_busy_reg <= 1'b0;
            srst_cnt_reg <= '0;
        end
        else if (srst_start)
        begin
            srst_busy_reg <= 1'b1;
            srst_cnt_reg <= '0;
        end
        else if (srst_busy_reg)
        begin
            if (srst_cnt_reg == SRST_LAST)
                srst_busy_reg <= 1'b0;
            srst_cnt_reg <= srst_cnt_reg + 1'b1;
        end
    end

    // Unit enables, forced off during soft reset
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rcv_on_reg <= 1'b0;
            tx_on_reg <= 1'b0;
        end
        else if (srst_start || srst_busy_reg)
        begin
            rcv_on_reg <= 1'b0;
            tx_on_reg <= 1'b0;
        end
        else if (wr_cmd && pstrb_i[0])
        begin
            rcv_on_reg <= pwdata_i[CMD_RCV_ON_BIT];
            tx_on_reg <= pwdata_i[CMD_TX_ON_BIT];
        end
    end

    // Threshold and mask registers; soft reset leaves them alone
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_thresh_reg <= RX_THRESH_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
        end
        else
        begin
            if (wr_thr && pstrb_i[0])
                rx_thresh_reg[7:0] <= pwdata_i[7:0];
            if (wr_thr && pstrb_i[1])
                rx_thresh_reg[15:8] <= pwdata_i[15:8];
            if (wr_mask && pstrb_i[0])
                irq_mask_reg[7:0] <= pwdata_i[7:0];
            if (wr_mask && pstrb_i[1])
                irq_mask_reg[15:8] <= pwdata_i[15:8];
        end
    end

    // Read view
    always_comb
    begin
        erx_status = 8'h00;
        erx_status[ERX_GOOD_BIT] = early_good_pkt;
        erx_status[ERX_BAD_BIT] = early_bad_pkt;
        erx_status[ERX_OVW_BIT] = early_overwrite;
        erx_status[ERX_THRESH_BIT] = early_thresh_hit;
        cmd_value = 8'h00;
        cmd_value[CMD_SRST_BIT] = srst_busy_reg;
        cmd_value[CMD_RCV_ON_BIT] = rcv_on_reg;
        cmd_value[CMD_TX_ON_BIT] = tx_on_reg;
        poll_value = 8'h00;
        poll_value[POLL_URGENT_BIT] = urgent_queue_poll;
        poll_value[POLL_NORMAL_BIT] = normal_queue_poll;
        poll_value[POLL_FORCE_BIT] = force_soft_irq;
        irq_flags = 16'h0000;
        irq_flags[IRQ_DONE_BIT] = frame_done_irq;
        irq_flags[IRQ_ERR_BIT] = frame_err_irq;
        irq_flags[IRQ_SOFT_BIT] = soft_irq_flag;
    end

    always_comb
    begin
        case (paddr_i)
            EARLY_RX_STATUS_ADDR: rd_mux = {24'h000000, erx_status};
            CHIP_COMMAND_ADDR: rd_mux = {24'h000000, cmd_value};
            TX_POLL_TRIGGER_ADDR: rd_mux = {24'h000000, poll_value};
            RX_THRESH_ADDR: rd_mux = {16'h0000, rx_thresh_reg};
            IRQ_MASK_ADDR: rd_mux = {16'h0000, irq_mask_reg};
            IRQ_FLAGS_ADDR: rd_mux = {16'h0000, irq_flags};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Read data captured in setup; only the returned flags are cleared later
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prdata_reg <= 32'h00000000;
            flags_snap_reg <= 16'h0000;
        end
        else if (rd_setup)
        begin
            prdata_reg <= rd_mux;
            flags_snap_reg <= irq_flags;
        end
    end

    assign prdata_o = prdata_reg;
    assign rcv_on_o = rcv_on_reg;
    assign tx_on_o = tx_on_reg;
    assign soft_rst_o = srst_busy_reg;
    assign urgent_queue_poll_o = urgent_queue_poll;
    assign normal_queue_poll_o = normal_queue_poll;
    assign irq_o = |(irq_flags & irq_mask_reg);

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_good_set: assert property (good_end |=> early_good_pkt)
        else $error("early good flag not set after good packet");
    chk_bad_set: assert property (bad_end |=> early_bad_pkt && frame_err_irq)
        else $error("bad packet did not set bad and error flags");
    chk_ovw_meet: assert property (ptr_eq && !$past(ptr_eq) |=> early_overwrite)
        else $error("overwrite flag missed pointer meeting");
    chk_thresh_end: assert property (rx_pkt_done_i |=> !early_thresh_hit)
        else $error("threshold flag survived packet end");
    chk_thresh_irq: assert property ($rose(early_thresh_hit) |-> frame_done_irq)
        else $error("threshold hit without frame done interrupt");
    chk_srst_ends: assert property ($rose(srst_busy_reg) |-> ##[1:SRST_WAIT] !srst_busy_reg)
        else $error("soft reset did not finish in time");
    chk_srst_units: assert property (srst_busy_reg |-> !rcv_on_o && !tx_on_o)
        else $error("unit enabled during soft reset");
    chk_force_hold: assert property (force_soft_irq && soft_irq_flag |=> force_soft_irq)
        else $error("force bit cleared while soft flag set");
    chk_soft_trig: assert property (wr_poll && wbyte0[POLL_FORCE_BIT]
                                    |=> soft_irq_flag && force_soft_irq)
        else $error("software interrupt not raised");
    chk_urgent_drain: assert property (urgent_q_drained_i && !wr_poll
                                       |=> !urgent_queue_poll_o)
        else $error("urgent doorbell not cleared after drain");
    chk_err_w1c: assert property (wr_flags && wbyte0[IRQ_ERR_BIT] && !bad_end
                                  |=> !frame_err_irq)
        else $error("error flag not cleared by write one");

endmodule // mac_cmd_early_rx_regs

`default_nettype wire

// ==== tb/mac_cmd_early_rx_regs_test.sv ====
// Self-checking bench for the command, early-receive and polling registers.
// Assumes the register block answers APB with pready and a shortened soft reset.
`timescale 1ns/10ps
`default_nettype none

module mac_cmd_early_rx_regs_test;
    import mac_regs_pkg::*;

    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] paddr_i = '0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] pwdata_i = '0;
    logic [3:0] pstrb_i = 4'h0;
    logic pready_o;
    logic [31:0] prdata_o;
    logic pslverr_o;
    logic [4:0] ev = 5'h00;
    logic rx_active_i = 1'b0;
    logic [15:0] rx_byte_cnt_i = 16'h0000;
    logic [15:0] rx_wr_ptr_i = 16'h0010;
    logic [15:0] host_read_ptr_i = 16'h0020;
    logic rcv_on_o, tx_on_o, soft_rst_o, urgent_queue_poll_o, normal_queue_poll_o, irq_o;
    int n_errors = 0;
    int comparisons = 0;
    logic [31:0] rdat;
    logic rerr;

    always #2 sys_clk_i = ~sys_clk_i;

    mac_cmd_early_rx_regs #(.PTR_W(16), .CNT_W(16), .SRST_CYCLES(6)) dut
    (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .rx_pkt_done_i(ev[0]), .rx_pkt_err_i(ev[1]), .rx_active_i(rx_active_i),
        .rx_byte_cnt_i(rx_byte_cnt_i), .rx_wr_ptr_i(rx_wr_ptr_i),
        .host_read_ptr_i(host_read_ptr_i), .rx_rewind_i(ev[2]),
        .urgent_q_drained_i(ev[3]), .normal_q_drained_i(ev[4]),
        .rcv_on_o(rcv_on_o), .tx_on_o(tx_on_o), .soft_rst_o(soft_rst_o),
        .urgent_queue_poll_o(urgent_queue_poll_o), .normal_queue_poll_o(normal_queue_poll_o),
        .irq_o(irq_o)
    );

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer: setup, then access held until pready
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        bit done;
        done = 0;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= 4'hF;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        for (int i = 0; i < 20 && !done; i++)
        begin
            @(posedge sys_clk_i);
            if (pready_o === 1'b1)
            begin
                done = 1;
                r = prdata_o;
                e = pslverr_o;
            end
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (!done)
        begin
            n_errors++;
            final_report();
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        // Let the written flops settle before callers sample outputs
        @(posedge sys_clk_i);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask

    // Datapath event pulse for one cycle, then a cycle to land
    task automatic pulse(input logic [4:0] v);
        @(posedge sys_clk_i);
        ev <= v;
        @(posedge sys_clk_i);
        ev <= 5'h00;
        @(posedge sys_clk_i);
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    initial
    begin
        logic [ADDR_W-1:0] regs [5];
        bit gone;
        regs = '{EARLY_RX_STATUS_ADDR, CHIP_COMMAND_ADDR, TX_POLL_TRIGGER_ADDR,
                 IRQ_MASK_ADDR, IRQ_FLAGS_ADDR};
        gone = 0;
        wait_cycles(3);
        rst_n_i <= 1'b1;
        // Reset values
        foreach (regs[i]) rd_chk(regs[i], 32'h0000_0000);
        check({31'h0, irq_o}, 32'h0000_0000);
        wr(IRQ_MASK_ADDR, 32'h0000_0103);
        // Good and bad packet ends
        pulse(5'h01);
        check({31'h0, irq_o}, 32'h0000_0001);
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0008);
        wr(EARLY_RX_STATUS_ADDR, 32'h0000_0008);
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0000);
        wr(IRQ_FLAGS_ADDR, 32'h0000_0001);
        check({31'h0, irq_o}, 32'h0000_0000);
        pulse(5'h03);
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0004);
        rd_chk(IRQ_FLAGS_ADDR, 32'h0000_0002);
        pulse(5'h03);
        check({31'h0, irq_o}, 32'h0000_0001);
        wr(IRQ_FLAGS_ADDR, 32'h0000_0002);
        check({31'h0, irq_o}, 32'h0000_0000);
        wr(EARLY_RX_STATUS_ADDR, 32'h0000_0004);
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0000);
        // Threshold: equal count does not set, one above does
        wr(CHIP_COMMAND_ADDR, 32'h0000_0008);
        check({30'h0, rcv_on_o, tx_on_o}, 32'h0000_0002);
        wr(RX_THRESH_ADDR, 32'h0000_0004);
        @(posedge sys_clk_i);
        rx_active_i <= 1'b1;
        rx_byte_cnt_i <= 16'h0004;
        wait_cycles(3);
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0000);
        rx_byte_cnt_i <= 16'h0005;
        wait_cycles(3);
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0001);
        rd_chk(IRQ_FLAGS_ADDR, 32'h0000_0001);
        @(posedge sys_clk_i);
        ev <= 5'h01;
        rx_active_i <= 1'b0;
        rx_byte_cnt_i <= 16'h0000;
        @(posedge sys_clk_i);
        ev <= 5'h00;
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0008);
        rd_chk(IRQ_FLAGS_ADDR, 32'h0000_0001);
        wr(EARLY_RX_STATUS_ADDR, 32'h0000_000F);
        // Overwrite on pointer match, again on rewind
        @(posedge sys_clk_i);
        rx_wr_ptr_i <= 16'h0020;
        wait_cycles(2);
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0002);
        wr(EARLY_RX_STATUS_ADDR, 32'h0000_0002);
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0000);
        pulse(5'h04);
        rd_chk(EARLY_RX_STATUS_ADDR, 32'h0000_0002);
        // Enables, then soft reset
        wr(CHIP_COMMAND_ADDR, 32'h0000_000C);
        rd_chk(CHIP_COMMAND_ADDR, 32'h0000_000C);
        check({30'h0, rcv_on_o, tx_on_o}, 32'h0000_0003);
        wr(CHIP_COMMAND_ADDR, 32'h0000_0010);
        rd_chk(CHIP_COMMAND_ADDR, 32'h0000_0010);
        check({29'h0, soft_rst_o, rcv_on_o, tx_on_o}, 32'h0000_0004);
        for (int i = 0; i < 20 && !gone; i++)
        begin
            @(posedge sys_clk_i);
            gone = (soft_rst_o === 1'b0);
        end
        check({31'h0, gone}, 32'h0000_0001);
        rd_chk(CHIP_COMMAND_ADDR, 32'h0000_0000);
        rd_chk(IRQ_MASK_ADDR, 32'h0000_0103);
        // Doorbells: zero writes ignored, drained pulses clear
        wr(TX_POLL_TRIGGER_ADDR, 32'h0000_00C0);
        check({30'h0, urgent_queue_poll_o, normal_queue_poll_o}, 32'h0000_0003);
        wr(TX_POLL_TRIGGER_ADDR, 32'h0000_0000);
        rd_chk(TX_POLL_TRIGGER_ADDR, 32'h0000_00C0);
        pulse(5'h08);
        rd_chk(TX_POLL_TRIGGER_ADDR, 32'h0000_0040);
        pulse(5'h10);
        rd_chk(TX_POLL_TRIGGER_ADDR, 32'h0000_0000);
        // Forced software interrupt
        wr(TX_POLL_TRIGGER_ADDR, 32'h0000_0001);
        wait_cycles(1);
        check({31'h0, irq_o}, 32'h0000_0001);
        wait_cycles(4);
        rd_chk(TX_POLL_TRIGGER_ADDR, 32'h0000_0001);
        wr(IRQ_FLAGS_ADDR, 32'h0000_0100);
        wait_cycles(2);
        check({31'h0, irq_o}, 32'h0000_0000);
        rd_chk(TX_POLL_TRIGGER_ADDR, 32'h0000_0000);
        // Unmapped address
        apb(1'b0, 12'h004, 32'h0, rdat, rerr);
        check({31'h0, rerr}, 32'h0000_0001);
        check(rdat, 32'h0000_0000);
        final_report();
    end
endmodule // mac_cmd_early_rx_regs_test

`default_nettype wire
